// [include/gpp_pkg.sv]
// Shared constants, register map and state codes of the pin and pulse port.
package gpp_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] OFF_DATA_LVL = 8'h00;
  localparam logic [7:0] OFF_ADDR_LVL = 8'h04;
  localparam logic [7:0] OFF_SPEC_LVL = 8'h08;
  localparam logic [7:0] OFF_ANLG_LVL = 8'h0C;
  localparam logic [7:0] OFF_DATA_DIR = 8'h10;
  localparam logic [7:0] OFF_ADDR_DIR = 8'h14;
  localparam logic [7:0] OFF_SPEC_DIR = 8'h18;
  localparam logic [7:0] OFF_ANLG_DIR = 8'h1C;
  localparam logic [7:0] OFF_CMD = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h24;
  localparam logic [7:0] OFF_RESULT = 8'h28;

  // Command word fields.
  localparam int CMD_IDX_LSB = 0;
  localparam int CMD_OP_LSB = 8;
  localparam int CMD_DUR_LSB = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ERR_BIT = 1;

  // Command opcodes.
  localparam logic [3:0] OP_HIGH = 4'h1;
  localparam logic [3:0] OP_LOW = 4'h2;
  localparam logic [3:0] OP_FLOAT = 4'h3;
  localparam logic [3:0] OP_SAMPLE = 4'h4;
  localparam logic [3:0] OP_TEST = 4'h5;
  localparam logic [3:0] OP_MEAS_LOW = 4'h6;
  localparam logic [3:0] OP_MEAS_HIGH = 4'h7;
  localparam logic [3:0] OP_GEN_LOW = 4'h8;
  localparam logic [3:0] OP_GEN_HIGH = 4'h9;

  // Values after reset: every pin an input, every latch low, except the memory power pin, which is a high output.
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] LVL_RST = 8'h00;
  localparam logic [5:0] ANLG_DIR_RST = 6'h3F;
  localparam logic [5:0] ANLG_LVL_RST = 6'h00;
  localparam logic [7:0] TRUE_BYTE = 8'hFF;
  localparam logic [7:0] FALSE_BYTE = 8'h00;
  localparam int MAX_PIN_IDX = 15;

  // Pulse tick of 10 us at a 40 ns clock.
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_US = 10;
  localparam int TICK_CYC = (TICK_US * 1000) / CLK_PERIOD_NS;
  localparam logic [15:0] TICK_FULL = 16'hFFFF;

  // Sequencer states, one-hot.
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_SAMPLE = 5'b00010,
    S_WAIT_IDLE = 5'b00100,
    S_WAIT_EDGE = 5'b01000,
    S_PULSE = 5'b10000
  } gpp_state_t;

endpackage

// [logic/gpp_pulse_port.sv]
// General-purpose pin block with port access and pulse timing over APB.
//
// Function
// - Single-pin commands take a byte pin index from 0 to 15.
// - Indices 0 to 7 select data port bits 0 to 7.
// - Indices 8 to 13 select address bits 0-5; 14, 15 address bits 6, 7.
// - Drive-high makes the pin an output driven high at once.
// - Drive-low makes the pin an output driven low at once.
// - Float turns the pin driver off without sampling it.
// - Sample makes the pin an input, then returns true if high.
// - Level test returns 255 for a high pin, 0 for low.
// - Level test leaves the pin direction untouched.
// - Port reads return the current levels of all eight pins.
// - The special port aliases the address port for all accesses.
// - The analog port read returns its six pin levels in one byte.
// - A port write drives all eight latches from the written byte.
// - An analog port write sets its six latches from six bits.
// - Each port has a direction register; a cleared bit means output.
// - A direction write replaces all eight direction bits.
// - The analog direction register is six bits of one byte.
// - Turning off or lowering the memory power pin resets the device.
// - Low-pulse measure counts 10 us units; zero if none or too long.
// - High-pulse measure counts 10 us units; zero if none or too long.
// - Low-pulse generation holds the pin latch low count times 10 us; the pin direction is left as it was.
// - High-pulse generation holds the pin latch high count times 10 us; the pin direction is left as it was.
`timescale 1ns/1ps
module gpp_pulse_port import gpp_pkg::*; #(
  parameter bit HAS_MEM_PWR = 1'b1,
  parameter int MEM_PWR_BIT = 5,
  parameter int TICK_CYCLES = TICK_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] data_pin_in,
  output logic [7:0] data_pin_out,
  output logic [7:0] data_pin_oe_n,
  input wire logic [7:0] addr_pin_in,
  output logic [7:0] addr_pin_out,
  output logic [7:0] addr_pin_oe_n,
  input wire logic [5:0] anlg_pin_in,
  output logic [5:0] anlg_pin_out,
  output logic [5:0] anlg_pin_oe_n,
  output logic mem_pwr_reset
);

  initial begin
    if (MEM_PWR_BIT < 0 || MEM_PWR_BIT > 5) begin
      $error("gpp_pulse_port: MEM_PWR_BIT must be 0 to 5");
    end
  end

  typedef struct packed {
    logic [7:0] dlvl;
    logic [7:0] alvl;
    logic [7:0] ddir;
    logic [7:0] adir;
    logic [5:0] vlvl;
    logic [5:0] vdir;
    gpp_state_t st;
    logic [3:0] pin;
    logic act;
    logic [15:0] dur;
    logic [15:0] res;
    logic err;
    logic prst;
    logic [31:0] rdat;
  } gpp_regs_t;

  // The memory power pin starts as a driven-high output, so the block does
  // not hold itself in reset from the first cycle on.
  localparam logic [5:0] PWR_MASK = 6'(HAS_MEM_PWR) << MEM_PWR_BIT;
  localparam gpp_regs_t RST_IMG = '{
    dlvl: LVL_RST, alvl: LVL_RST, ddir: DIR_RST, adir: DIR_RST,
    vlvl: ANLG_LVL_RST | PWR_MASK, vdir: ANLG_DIR_RST & ~PWR_MASK,
    st: S_IDLE, pin: 4'h0, act: 1'b0, dur: 16'h0000, res: 16'h0000,
    err: 1'b0, prst: 1'b0, rdat: 32'h0000_0000
  };

  gpp_regs_t q, d;
  logic [15:0] pins16;
  logic [15:0] dir16;
  logic [15:0] lvl16;
  logic sel_lvl;
  logic setup;
  logic wr;
  logic hit;
  logic cmd_go;
  logic [3:0] op;
  logic [3:0] idx;
  logic tmr_clr;
  logic tick;
  logic [15:0] tcount;
  logic tfull;

  // Turns a pin level into the byte that single-pin queries return.
  function automatic logic [7:0] truth(input logic lvl);
    return lvl ? TRUE_BYTE : FALSE_BYTE;
  endfunction

  // True when an offset belongs to the register map.
  function automatic logic mapped(input logic [7:0] a);
    case (a)
      OFF_DATA_LVL, OFF_ADDR_LVL, OFF_SPEC_LVL, OFF_ANLG_LVL,
      OFF_DATA_DIR, OFF_ADDR_DIR, OFF_SPEC_DIR, OFF_ANLG_DIR,
      OFF_CMD, OFF_STATUS, OFF_RESULT: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin numbering: the data port fills indices 0-7 and the address port
  // 8-15, so one 16-bit view serves every single-pin command.
  assign pins16 = {addr_pin_in, data_pin_in};
  assign sel_lvl = pins16[q.pin];

  // Bus decode; the slave never inserts wait states.
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign hit = mapped(paddr);
  assign op = pwdata[CMD_OP_LSB +: 4];
  assign idx = pwdata[CMD_IDX_LSB +: 4];
  assign cmd_go = wr && (paddr == OFF_CMD) && (q.st == S_IDLE)
                  && (pwdata[CMD_IDX_LSB +: 8] <= 8'(MAX_PIN_IDX));

  gpp_tick_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .clr(tmr_clr),
    .tick(tick),
    .count(tcount),
    .full(tfull)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register writes, command start and the pulse sequencer.
  always_comb begin
    d = q;
    d.prst = 1'b0;
    tmr_clr = 1'b0;
    dir16 = {q.adir, q.ddir};
    lvl16 = {q.alvl, q.dlvl};

    // Read data is captured in the setup cycle so it leaves a flip-flop.
    if (setup) begin
      case (paddr)
        OFF_DATA_LVL: d.rdat = {24'h000000, data_pin_in};
        OFF_ADDR_LVL: d.rdat = {24'h000000, addr_pin_in};
        OFF_SPEC_LVL: d.rdat = {24'h000000, addr_pin_in};
        OFF_ANLG_LVL: d.rdat = {26'h0000000, anlg_pin_in};
        OFF_DATA_DIR: d.rdat = {24'h000000, q.ddir};
        OFF_ADDR_DIR: d.rdat = {24'h000000, q.adir};
        OFF_SPEC_DIR: d.rdat = {24'h000000, q.adir};
        OFF_ANLG_DIR: d.rdat = {26'h0000000, q.vdir};
        OFF_CMD: d.rdat = {q.dur, 12'h000, q.pin};
        OFF_STATUS: d.rdat = {30'h00000000, q.err, q.st != S_IDLE};
        OFF_RESULT: d.rdat = {16'h0000, q.res};
        default: d.rdat = 32'h0000_0000;
      endcase
    end

    // Port and direction writes; the special port lands on the address port.
    if (wr) begin
      case (paddr)
        OFF_DATA_LVL: lvl16[7:0] = pwdata[7:0];
        OFF_ADDR_LVL: lvl16[15:8] = pwdata[7:0];
        OFF_SPEC_LVL: lvl16[15:8] = pwdata[7:0];
        OFF_ANLG_LVL: d.vlvl = pwdata[5:0];
        OFF_DATA_DIR: dir16[7:0] = pwdata[7:0];
        OFF_ADDR_DIR: dir16[15:8] = pwdata[7:0];
        OFF_SPEC_DIR: dir16[15:8] = pwdata[7:0];
        OFF_ANLG_DIR: d.vdir = pwdata[5:0];
        OFF_STATUS: begin
          if (pwdata[STAT_ERR_BIT]) begin
            d.err = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // A command while busy, or with a bad index, only flags; a bad opcode also loads pin and dur.
    if (wr && paddr == OFF_CMD && !cmd_go) begin
      d.err = 1'b1;
    end

    if (cmd_go) begin
      d.pin = idx;
      d.dur = pwdata[CMD_DUR_LSB +: 16];
      case (op)
        OP_HIGH: begin
          dir16[idx] = 1'b0;
          lvl16[idx] = 1'b1;
        end
        OP_LOW: begin
          dir16[idx] = 1'b0;
          lvl16[idx] = 1'b0;
        end
        OP_FLOAT: dir16[idx] = 1'b1;
        OP_SAMPLE: begin
          dir16[idx] = 1'b1;
          d.st = S_SAMPLE;
        end
        OP_TEST: d.res = {8'h00, truth(pins16[idx])};
        OP_MEAS_LOW, OP_MEAS_HIGH: begin
          d.act = (op == OP_MEAS_HIGH);
          d.st = S_WAIT_IDLE;
          tmr_clr = 1'b1;
        end
        OP_GEN_LOW, OP_GEN_HIGH: begin
          // A zero count gives no pulse; the pin keeps its level.
          if (pwdata[CMD_DUR_LSB +: 16] != 16'h0000) begin
            d.act = (op == OP_GEN_HIGH);
            lvl16[idx] = (op == OP_GEN_HIGH);
            d.st = S_PULSE;
            tmr_clr = 1'b1;
          end
        end
        default: d.err = 1'b1;
      endcase
    end

    // Sequencer. Waiting for the idle level and for the pulse to start share one
    // 16-bit tick budget, and timing the pulse restarts it, so a pin that never moves returns zero.
    case (q.st)
      S_IDLE: begin
      end
      S_SAMPLE: begin
        d.res = {8'h00, truth(sel_lvl)};
        d.st = S_IDLE;
      end
      S_WAIT_IDLE: begin
        if (sel_lvl != q.act) begin
          d.st = S_WAIT_EDGE;
        end else if (tick && tfull) begin
          d.res = 16'h0000;
          d.st = S_IDLE;
        end
      end
      S_WAIT_EDGE: begin
        if (sel_lvl == q.act) begin
          d.st = S_PULSE;
          tmr_clr = 1'b1;
        end else if (tick && tfull) begin
          d.res = 16'h0000;
          d.st = S_IDLE;
        end
      end
      S_PULSE: begin
        if (q.dur != 16'h0000) begin
          // Generating: release after exactly dur ticks.
          if (tick && tcount == q.dur - 16'h0001) begin
            lvl16[q.pin] = !q.act;
            d.st = S_IDLE;
          end
        end else if (sel_lvl != q.act) begin
          d.res = tcount;
          d.st = S_IDLE;
        end else if (tick && tfull) begin
          d.res = 16'h0000;
          d.st = S_IDLE;
        end
      end
      default: d.st = S_IDLE;
    endcase

    // Measurements use dur as zero so the pulse state knows its job.
    if (cmd_go && (op == OP_MEAS_LOW || op == OP_MEAS_HIGH)) begin
      d.dur = 16'h0000;
    end

    {d.adir, d.ddir} = dir16;
    {d.alvl, d.dlvl} = lvl16;

    // Software switching the memory supply off or low restarts the block.
    if (HAS_MEM_PWR && wr && (paddr == OFF_ANLG_LVL || paddr == OFF_ANLG_DIR)
        && (d.vdir[MEM_PWR_BIT] || !d.vlvl[MEM_PWR_BIT])) begin
      d = RST_IMG;
      d.prst = 1'b1;
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= RST_IMG;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs. A set direction bit means input, which is the active-low
  // enable polarity, so the register drives the enable directly.
  assign data_pin_out = q.dlvl;
  assign data_pin_oe_n = q.ddir;
  assign addr_pin_out = q.alvl;
  assign addr_pin_oe_n = q.adir;
  assign anlg_pin_out = q.vlvl;
  assign anlg_pin_oe_n = q.vdir;
  assign mem_pwr_reset = q.prst;
  assign prdata = q.rdat;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_bad_index: assert property (
    wr && paddr == OFF_CMD && pwdata[7:0] > 8'(MAX_PIN_IDX) |=> q.err)
    else $error("Out-of-range pin index not flagged.");
  a_drive_high: assert property (
    cmd_go && op == OP_HIGH |=> !dir16[q.pin] && lvl16[q.pin])
    else $error("Drive-high did not make a high output.");
  a_drive_low: assert property (
    cmd_go && op == OP_LOW |=> !dir16[q.pin] && !lvl16[q.pin])
    else $error("Drive-low did not make a low output.");
  a_float_quiet: assert property (
    cmd_go && op == OP_FLOAT |=> dir16[q.pin] && $stable(q.res))
    else $error("Float did not release the pin quietly.");
  a_test_value: assert property (
    cmd_go && op == OP_TEST
    |=> q.res == {8'h00, truth($past(pins16[idx]))})
    else $error("Level test returned a wrong byte.");
  a_test_keeps_dir: assert property (
    cmd_go && op == OP_TEST |=> {q.adir, q.ddir} == $past({q.adir, q.ddir}))
    else $error("Level test changed a direction bit.");
  a_spec_alias: assert property (
    setup && !pwrite && paddr == OFF_SPEC_LVL
    |=> prdata[7:0] == $past(addr_pin_in))
    else $error("Special port read does not mirror the address port.");
  a_dir_write: assert property (
    wr && paddr == OFF_DATA_DIR |=> data_pin_oe_n == $past(pwdata[7:0]))
    else $error("Direction write did not reach the pin enables.");
  a_pwr_reset: assert property (
    mem_pwr_reset |-> !anlg_pin_oe_n[MEM_PWR_BIT] && q.st == S_IDLE)
    else $error("Memory power reset left the block in a wrong state.");
  a_gen_release: assert property (
    q.st == S_PULSE && q.dur != 16'h0000 && tick
    && tcount == q.dur - 16'h0001
    |=> q.st == S_IDLE && lvl16[q.pin] == !$past(q.act))
    else $error("Generated pulse did not end after its count.");
  a_meas_overflow: assert property (
    q.st == S_PULSE && q.dur == 16'h0000 && tick && tfull
    && sel_lvl == q.act |=> q.st == S_IDLE && q.res == 16'h0000)
    else $error("Overlong pulse did not return zero.");
  c_measure_done: cover property (
    q.st == S_PULSE && q.dur == 16'h0000 && sel_lvl != q.act);
  c_generate_done: cover property (
    q.st == S_PULSE && q.dur != 16'h0000 ##1 q.st == S_IDLE);
  c_sample_cmd: cover property (cmd_go && op == OP_SAMPLE);
  c_pwr_reset: cover property (mem_pwr_reset);

endmodule // gpp_pulse_port

// [logic/gpp_tick_timer.sv]
// Ten-microsecond tick prescaler with a saturating 16-bit tick counter.
`timescale 1ns/1ps
module gpp_tick_timer import gpp_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  output logic tick,
  output logic [15:0] count,
  output logic full
);

  initial begin
    if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin
      $error("gpp_tick_timer: TICK_CYCLES out of range");
    end
  end

  typedef struct packed {
    logic [15:0] pre;
    logic [15:0] cnt;
  } gpp_tmr_t;

  localparam logic [15:0] PRE_LAST = 16'(TICK_CYCLES - 1);

  gpp_tmr_t q, d;

  ////////////////////////////////////////////////////////////////////////////
  // A clear restarts the prescaler too, so the first tick lands a full
  // period after the clear and short pulses are not overcounted.
  always_comb begin
    d = q;
    tick = (q.pre == PRE_LAST);
    if (clr) begin
      d.pre = 16'h0000;
      d.cnt = 16'h0000;
    end else if (tick) begin
      d.pre = 16'h0000;
      if (q.cnt != TICK_FULL) begin
        d.cnt = q.cnt + 16'h0001;
      end
    end else begin
      d.pre = q.pre + 16'h0001;
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign count = q.cnt;
  assign full = (q.cnt == TICK_FULL);

endmodule // gpp_tick_timer

// [tb/gpp_pin_model.sv]
// External circuitry on one port: pull-ups plus a bench-controlled driver.
`timescale 1ns/1ps
module gpp_pin_model #(
  parameter int W = 8
) (
  input wire logic [W-1:0] pin_out,
  input wire logic [W-1:0] pin_oe_n,
  input wire logic [W-1:0] ext_en,
  input wire logic [W-1:0] ext_val,
  output logic [W-1:0] pin_lvl
);
  // The device driver wins; a released, undriven pin is pulled high so an
  // unknown never reaches the sampling logic.
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (!pin_oe_n[i]) pin_lvl[i] = pin_out[i];
      else if (ext_en[i]) pin_lvl[i] = ext_val[i];
      else pin_lvl[i] = 1'b1;
    end
  end
endmodule // gpp_pin_model

// [tb/gpp_pulse_port_test.sv]
// Self-checking bench of the pin and pulse port over APB.
`timescale 1ns/1ps
module gpp_pulse_port_test import gpp_pkg::*;;
  localparam int TK = 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_pwr_reset;
  logic [7:0] paddr, d_out, d_oe_n, d_lvl, a_out, a_oe_n, a_lvl, d_ext, a_ext;
  logic [7:0] d_en, a_en;
  logic [5:0] v_en, v_ext;
  logic [31:0] pwdata, prdata, rd_q;
  logic [5:0] v_out, v_oe_n, v_lvl;
  logic last_err, pwr_seen;
  int fail_count, cmp_count, n;

  gpp_pulse_port #(.TICK_CYCLES(TK)) u_gpp_pulse_port (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .data_pin_in(d_lvl), .data_pin_out(d_out),
    .data_pin_oe_n(d_oe_n), .addr_pin_in(a_lvl), .addr_pin_out(a_out),
    .addr_pin_oe_n(a_oe_n), .anlg_pin_in(v_lvl), .anlg_pin_out(v_out),
    .anlg_pin_oe_n(v_oe_n), .mem_pwr_reset(mem_pwr_reset));
  gpp_pin_model #(.W(8)) u_gpp_pin_model_d (.pin_out(d_out),
    .pin_oe_n(d_oe_n), .ext_en(d_en), .ext_val(d_ext), .pin_lvl(d_lvl));
  gpp_pin_model #(.W(8)) u_gpp_pin_model_a (.pin_out(a_out),
    .pin_oe_n(a_oe_n), .ext_en(a_en), .ext_val(a_ext), .pin_lvl(a_lvl));
  gpp_pin_model #(.W(6)) u_gpp_pin_model_v (.pin_out(v_out),
    .pin_oe_n(v_oe_n), .ext_en(v_en), .ext_val(v_ext), .pin_lvl(v_lvl));

  // Free-running bench clock of 40 ns.
  always #20 pclk = ~pclk;

  // Latch any power-pin reset pulse; it lasts only one cycle.
  // Cleared during reset so that this process is the flag's only driver.
  always @(posedge pclk) begin
    if (!presetn) pwr_seen <= 1'b0;
    else if (mem_pwr_reset === 1'b1) pwr_seen <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Verdict, comparison and bus tasks.
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      fail_count++;
      $display("ERROR %0t bus wait ran out", $time);
      give_verdict();
    end
    rd_q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cmd(input logic [3:0] op, input logic [7:0] idx,
                     input logic [15:0] dur);
    apb(1'b1, OFF_CMD, {dur, 4'h0, op, idx});
  endtask

  // Poll busy with a bound; a stuck sequencer ends the run.
  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      apb(1'b0, OFF_STATUS, 32'h0);
      k++;
    end while (rd_q[STAT_BUSY_BIT] !== 1'b0 && k < 300);
    if (k >= 300) begin
      fail_count++;
      $display("ERROR %0t busy never cleared", $time);
      give_verdict();
    end
  endtask

  // Count cycles for which data pin 0 holds the given level.
  task automatic span(input logic lvl);
    n = 0;
    do begin
      @(negedge pclk);
      if (d_out[0] === lvl) n++;
    end while (d_out[0] === lvl && n < 200);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    d_ext = 8'h00;
    a_ext = 8'h00;
    d_en = 8'hFF;
    a_en = 8'hFF;
    v_en = 6'h1F;
    v_ext = 6'h0A;
    fail_count = 0;
    cmp_count = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;

    apb(1'b0, OFF_DATA_DIR, 32'h0);
    chk(rd_q, 32'hFF, "data dir reset");
    apb(1'b0, OFF_ANLG_DIR, 32'h0);
    chk(rd_q, 32'h1F, "analog dir reset");
    apb(1'b0, OFF_ANLG_LVL, 32'h0);
    chk(rd_q, 32'h2A, "analog inputs and power pin");
    apb(1'b0, 8'h30, 32'h0);
    chk(32'(last_err), 32'h1, "unmapped read error");
    $display("test reset done");

    cmd(OP_HIGH, 8'd3, 16'h0);
    @(negedge pclk);
    chk(32'({d_oe_n[3], d_out[3]}), 32'h1, "pin 3 high");
    cmd(OP_LOW, 8'd14, 16'h0);
    @(negedge pclk);
    chk(32'({a_oe_n[6], a_out[6]}), 32'h0, "pin 14 low");
    cmd(OP_HIGH, 8'd15, 16'h0);
    @(negedge pclk);
    chk(32'({a_oe_n[7], a_out[7]}), 32'h1, "pin 15 high");
    cmd(OP_FLOAT, 8'd14, 16'h0);
    @(negedge pclk);
    chk(32'(a_oe_n[6]), 32'h1, "pin 14 float");
    cmd(OP_TEST, 8'd15, 16'h0);
    wait_idle();
    apb(1'b0, OFF_RESULT, 32'h0);
    chk(rd_q, 32'hFF, "test high pin");
    chk(32'(a_oe_n[7]), 32'h0, "test keeps direction");
    // Pin 15 was driven high: a sample taken after the release reads the far side's low, 0.
    cmd(OP_SAMPLE, 8'd15, 16'h0);
    wait_idle();
    apb(1'b0, OFF_RESULT, 32'h0);
    chk(rd_q, 32'h0, "sample after release");
    a_ext <= 8'h80;
    cmd(OP_SAMPLE, 8'd15, 16'h0);
    wait_idle();
    apb(1'b0, OFF_RESULT, 32'h0);
    chk(rd_q, 32'hFF, "sample result");
    chk(32'(a_oe_n[7]), 32'h1, "sample makes input");
    cmd(OP_TEST, 8'd8, 16'h0);
    wait_idle();
    apb(1'b0, OFF_RESULT, 32'h0);
    chk(rd_q, 32'h0, "test low pin");
    cmd(OP_HIGH, 8'd16, 16'h0);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(32'(rd_q[STAT_ERR_BIT]), 32'h1, "index 16 refused");
    apb(1'b1, OFF_STATUS, 32'h2);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(32'(rd_q[STAT_ERR_BIT]), 32'h0, "error flag cleared");
    cmd(4'hF, 8'd0, 16'h0);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(32'(rd_q[STAT_ERR_BIT]), 32'h1, "unknown opcode refused");
    apb(1'b1, OFF_STATUS, 32'h2);
    $display("test pin commands done");

    cmd(OP_HIGH, 8'd0, 16'h0);
    cmd(OP_GEN_LOW, 8'd0, 16'd3);
    span(1'b0);
    chk(32'(n), 32'(3 * TK), "low pulse length");
    cmd(OP_LOW, 8'd0, 16'h0);
    cmd(OP_GEN_HIGH, 8'd0, 16'd2);
    span(1'b1);
    chk(32'(n), 32'(2 * TK), "high pulse length");
    wait_idle();
    // Measure low, then high, on input pin 1 driven by the far side.
    for (int k = 0; k < 2; k++) begin
      d_ext <= {6'h0, ~k[0], 1'b0};
      cmd(k ? OP_MEAS_HIGH : OP_MEAS_LOW, 8'd1, 16'h0);
      repeat (6) @(posedge pclk);
      d_ext <= {6'h0, k[0], 1'b0};
      repeat (5 * TK + 2) @(posedge pclk);
      d_ext <= {6'h0, ~k[0], 1'b0};
      wait_idle();
      apb(1'b0, OFF_RESULT, 32'h0);
      chk(rd_q, 32'd5, "measured ticks");
    end
    $display("test pulses done");

    apb(1'b1, OFF_DATA_DIR, 32'h5A);
    @(negedge pclk);
    chk(32'(d_oe_n), 32'h5A, "data dir to enables");
    apb(1'b1, OFF_DATA_DIR, 32'h00);
    apb(1'b1, OFF_DATA_LVL, 32'hA5);
    @(negedge pclk);
    chk(32'(d_out), 32'hA5, "data port write");
    apb(1'b0, OFF_DATA_LVL, 32'h0);
    chk(rd_q, 32'hA5, "data port read");
    apb(1'b1, OFF_SPEC_DIR, 32'h3C);
    apb(1'b0, OFF_ADDR_DIR, 32'h0);
    chk(rd_q, 32'h3C, "special dir alias");
    // Release the far side so the address inputs show their pull-ups.
    a_en <= 8'h00;
    apb(1'b1, OFF_ADDR_LVL, 32'h81);
    apb(1'b0, OFF_SPEC_LVL, 32'h0);
    chk(rd_q, 32'(8'hBD), "special level alias");
    apb(1'b1, OFF_ANLG_LVL, 32'h25);
    apb(1'b1, OFF_ANLG_DIR, 32'h00);
    apb(1'b0, OFF_ANLG_LVL, 32'h0);
    chk(rd_q, 32'h25, "analog port");
    apb(1'b0, OFF_ANLG_DIR, 32'h0);
    chk(rd_q, 32'h00, "analog dir");
    chk(32'(pwr_seen), 32'h0, "no power reset yet");
    $display("test ports done");

    apb(1'b1, OFF_ANLG_DIR, 32'h3F);
    repeat (2) @(posedge pclk);
    chk(32'(pwr_seen), 32'h1, "power pin reset pulse");
    apb(1'b0, OFF_DATA_DIR, 32'h0);
    chk(rd_q, 32'hFF, "device reset by power pin");
    $display("test power reset done");
    give_verdict();
  end
endmodule // gpp_pulse_port_test
